// ==== hdl/cstl_pkg.sv ====
// Constants for the current sense trim and limit block
package cstl_pkg;
  localparam logic [7:0] CSTL_ADDR_PRI_READING = 8'h13;
  localparam logic [7:0] CSTL_ADDR_SEC_RESULT = 8'h18;
  localparam logic [7:0] CSTL_ADDR_PRI_SETUP = 8'h22;
  localparam logic [7:0] CSTL_ADDR_GAIN = 8'h23;
  localparam logic [7:0] CSTL_ADDR_OFFSET = 8'h24;
  localparam logic [7:0] CSTL_ADDR_DIGITAL = 8'h25;
  localparam logic [7:0] CSTL_ADDR_LIMIT = 8'h26;
  localparam logic [7:0] CSTL_ADDR_STATUS = 8'h28;
  localparam logic [7:0] CSTL_REG_RESET = 8'h00;
  // Field positions
  localparam int CSTL_HOLDOFF_LSB = 5;
  localparam int CSTL_HOLDOFF_MSB = 7;
  localparam int CSTL_PRI_THR_MSB = 4;
  localparam int CSTL_RANGE_LSB = 6;
  localparam int CSTL_RANGE_MSB = 7;
  localparam int CSTL_GAIN_NEG_BIT = 5;
  localparam int CSTL_GAIN_MAG_MSB = 4;
  localparam int CSTL_HIGHSIDE_BIT = 7;
  localparam int CSTL_OFFS_NEG_BIT = 6;
  localparam int CSTL_OFFS_MAG_MSB = 5;
  localparam int CSTL_STAT_PRI_BIT = 0;
  localparam int CSTL_STAT_SEC_BIT = 1;
  // Secondary range codes; 2'h3 is reserved
  localparam logic [1:0] CSTL_RANGE_37MV = 2'h0;
  localparam logic [1:0] CSTL_RANGE_75MV = 2'h1;
  localparam logic [1:0] CSTL_RANGE_150MV = 2'h2;
  // Holdoff timing, ns per code, and the clock period in ps
  localparam int CSTL_CLK_PERIOD_PS = 8000;
  localparam int CSTL_HOLDOFF_NS [8] = '{0, 40, 80, 120, 200, 400, 600, 800};
  localparam int CSTL_HOLDOFF_CNT_W = 7;
  localparam int CSTL_HOLDOFF_CYC1 = (40 * 1000 + CSTL_CLK_PERIOD_PS - 1) / CSTL_CLK_PERIOD_PS;

  // Least time rounds up to whole cycles
  function automatic logic [CSTL_HOLDOFF_CNT_W-1:0] cstl_holdoff_cycles(input logic [2:0] code);
    int ns;
    ns = CSTL_HOLDOFF_NS[code];
    return CSTL_HOLDOFF_CNT_W'((ns * 1000 + CSTL_CLK_PERIOD_PS - 1) / CSTL_CLK_PERIOD_PS);
  endfunction
endpackage

// ==== hdl/cstl_holdoff_if.sv ====
// Signals between the top and the holdoff timer
`timescale 1ns/100ps
`default_nettype none
interface cstl_holdoff_if;
  logic cycle_start;
  logic [2:0] code;
  logic holdoff;
  modport ctrl (output cycle_start, output code, input holdoff);
  modport timer (input cycle_start, input code, output holdoff);
endinterface
`default_nettype wire

// ==== hdl/cstl_holdoff_timer.sv ====
// Primary quick limit holdoff timer
`timescale 1ns/100ps
`default_nettype none
module cstl_holdoff_timer
  import cstl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  cstl_holdoff_if.timer hif
);
  logic [CSTL_HOLDOFF_CNT_W-1:0] cnt_r, cnt_nxt;
  logic hold_r, hold_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (hif.cycle_start) begin
      cnt_nxt = cstl_holdoff_cycles(hif.code);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    hold_nxt = (cnt_nxt != '0);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      hold_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign hif.holdoff = hold_r;

  holdoff_len_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (hif.cycle_start && hif.code == 3'h1) ##1 (!hif.cycle_start)[*5] |-> hold_r ##1 !hold_r)
    else $error("holdoff did not end after 40 ns");
  holdoff_on_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (hif.cycle_start && hif.code == 3'h7) |=> hold_r[*8])
    else $error("holdoff not held for longest code");
  holdoff_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (hif.cycle_start && hif.code == 3'h0) |=> !hold_r)
    else $error("zero holdoff code held off");
endmodule // cstl_holdoff_timer
`default_nettype wire

// ==== hdl/cstl_top.sv ====
// Current sense trim registers and limit compare
// Operation
// - The quick holdoff output is raised after each cycle start for 0 to 800 ns by code; the primary flag is not gated by it.
// - The primary flag sets when the primary reading is strictly above the threshold.
// - The primary threshold is five bits, 0 to 31, steps of 43.125 mV, zero is zero.
// - A two-bit range code picks 37.5, 75 or 150 mV full scale.
// - Gain register bit 5 set gives negative gain correction, clear gives positive.
// - Gain register bits 4:0 give the gain correction magnitude.
// - Offset register bit 7 is one for high-side sensing, zero for low-side.
// - Offset register bit 6 set gives a negative offset, clear a positive one.
// - Offset register bits 5:0 give the common-mode offset magnitude.
// - An 8-bit digital trim adjusts the secondary result readable at 0x18.
// - The secondary flag sets when the result is strictly above the 8-bit limit.
`timescale 1ns/100ps
`default_nettype none
module cstl_top
  import cstl_pkg::*;
#(
  parameter int PRI_W = 5,
  parameter int SEC_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_cycle_start,
  input wire logic [PRI_W-1:0] i_primary_reading,
  input wire logic [SEC_W-1:0] i_secondary_raw,
  output logic [7:0] o_reg_rdata,
  output logic o_primary_over,
  output logic o_secondary_over,
  output logic o_quick_holdoff,
  output logic [1:0] o_secondary_range,
  output logic o_gain_negative,
  output logic [4:0] o_gain_magnitude,
  output logic o_highside,
  output logic o_offset_negative,
  output logic [5:0] o_offset_magnitude
);
  logic [7:0] pri_setup_r, pri_setup_nxt;
  logic [7:0] gain_r, gain_nxt;
  logic [7:0] offs_r, offs_nxt;
  logic [7:0] dig_r, dig_nxt;
  logic [7:0] lim_r, lim_nxt;
  logic [SEC_W-1:0] result_r, result_nxt;
  logic pri_over_r, pri_over_nxt;
  logic sec_over_r, sec_over_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [PRI_W-1:0] pri_thr;
  cstl_holdoff_if hif ();

  // Signed trim added to the raw reading, clipped at both ends
  function automatic logic [SEC_W-1:0] sat_adjust(input logic [SEC_W-1:0] raw,
                                                  input logic [7:0] adj);
    logic signed [SEC_W+1:0] sum;
    sum = $signed({2'b00, raw}) + (SEC_W+2)'($signed(adj));
    if (sum < 0) return '0;
    if (sum > $signed({2'b00, {SEC_W{1'b1}}})) return '1;
    return sum[SEC_W-1:0];
  endfunction

  // Threshold kept at code width; no sequencing versus trim is enforced here
  assign pri_thr = PRI_W'(pri_setup_r[CSTL_PRI_THR_MSB:0]);

  always_comb begin
    pri_setup_nxt = pri_setup_r;
    gain_nxt = gain_r;
    offs_nxt = offs_r;
    dig_nxt = dig_r;
    lim_nxt = lim_r;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        CSTL_ADDR_PRI_SETUP: pri_setup_nxt = i_reg_wdata;
        CSTL_ADDR_GAIN: gain_nxt = i_reg_wdata;
        CSTL_ADDR_OFFSET: offs_nxt = i_reg_wdata;
        CSTL_ADDR_DIGITAL: dig_nxt = i_reg_wdata;
        CSTL_ADDR_LIMIT: lim_nxt = i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    result_nxt = sat_adjust(i_secondary_raw, dig_r);
    pri_over_nxt = (i_primary_reading > pri_thr);
    sec_over_nxt = (result_r > SEC_W'(lim_r));
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        CSTL_ADDR_PRI_READING: rdata_nxt = 8'(i_primary_reading);
        CSTL_ADDR_SEC_RESULT: rdata_nxt = 8'(result_r);
        CSTL_ADDR_PRI_SETUP: rdata_nxt = pri_setup_r;
        CSTL_ADDR_GAIN: rdata_nxt = gain_r;
        CSTL_ADDR_OFFSET: rdata_nxt = offs_r;
        CSTL_ADDR_DIGITAL: rdata_nxt = dig_r;
        CSTL_ADDR_LIMIT: rdata_nxt = lim_r;
        CSTL_ADDR_STATUS: begin
          rdata_nxt = 8'h00;
          rdata_nxt[CSTL_STAT_PRI_BIT] = pri_over_r;
          rdata_nxt[CSTL_STAT_SEC_BIT] = sec_over_r;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pri_setup_r <= CSTL_REG_RESET;
      gain_r <= CSTL_REG_RESET;
      offs_r <= CSTL_REG_RESET;
      dig_r <= CSTL_REG_RESET;
      lim_r <= CSTL_REG_RESET;
    end else begin
      pri_setup_r <= pri_setup_nxt;
      gain_r <= gain_nxt;
      offs_r <= offs_nxt;
      dig_r <= dig_nxt;
      lim_r <= lim_nxt;
    end
  end

  // Compare stage; flags are live levels, so no clear path is needed
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      result_r <= '0;
      pri_over_r <= 1'b0;
      sec_over_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      pri_over_r <= pri_over_nxt;
      sec_over_r <= sec_over_nxt;
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign hif.cycle_start = i_cycle_start;
  assign hif.code = pri_setup_r[CSTL_HOLDOFF_MSB:CSTL_HOLDOFF_LSB];

  cstl_holdoff_timer u_holdoff (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .hif(hif.timer)
  );

  assign o_reg_rdata = rdata_r;
  assign o_primary_over = pri_over_r;
  assign o_secondary_over = sec_over_r;
  assign o_quick_holdoff = hif.holdoff;
  assign o_secondary_range = gain_r[CSTL_RANGE_MSB:CSTL_RANGE_LSB];
  assign o_gain_negative = gain_r[CSTL_GAIN_NEG_BIT];
  assign o_gain_magnitude = gain_r[CSTL_GAIN_MAG_MSB:0];
  assign o_highside = offs_r[CSTL_HIGHSIDE_BIT];
  assign o_offset_negative = offs_r[CSTL_OFFS_NEG_BIT];
  assign o_offset_magnitude = offs_r[CSTL_OFFS_MAG_MSB:0];

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  pri_flag_set_a: assert property ((i_primary_reading > pri_thr) |=> o_primary_over)
    else $error("primary flag missed an over reading");
  pri_flag_clr_a: assert property ((i_primary_reading <= pri_thr) |=> !o_primary_over)
    else $error("primary flag set at or below threshold");
  pri_zero_thr_a: assert property ((pri_thr == '0 && i_primary_reading == PRI_W'(1))
    |=> o_primary_over) else $error("zero threshold not zero");
  sec_flag_a: assert property (o_secondary_over == $past(result_r > SEC_W'(lim_r)))
    else $error("secondary flag disagrees with limit");
  sec_adjust_a: assert property (($stable(dig_r) && dig_r == 8'h00)
    |=> result_r == $past(i_secondary_raw)) else $error("zero trim changed the result");
  gain_write_a: assert property ((i_reg_wr && i_reg_addr == CSTL_ADDR_GAIN)
    |=> o_gain_negative == $past(i_reg_wdata[5]) && o_gain_magnitude == $past(i_reg_wdata[4:0]))
    else $error("gain fields not stored");
  offs_write_a: assert property ((i_reg_wr && i_reg_addr == CSTL_ADDR_OFFSET)
    |=> o_highside == $past(i_reg_wdata[7]) && o_offset_negative == $past(i_reg_wdata[6])
    && o_offset_magnitude == $past(i_reg_wdata[5:0])) else $error("offset fields not stored");
  range_write_a: assert property ((i_reg_wr && i_reg_addr == CSTL_ADDR_GAIN)
    |=> o_secondary_range == $past(i_reg_wdata[7:6])) else $error("range code not stored");
  result_read_a: assert property ((i_reg_rd && i_reg_addr == CSTL_ADDR_SEC_RESULT)
    |=> o_reg_rdata == $past(8'(result_r))) else $error("result read wrong");
  // Register store and readback paths
  setup_write_a: assert property ((i_reg_wr && i_reg_addr == CSTL_ADDR_PRI_SETUP)
    |=> pri_thr == PRI_W'($past(i_reg_wdata[CSTL_PRI_THR_MSB:0])))
    else $error("threshold not stored");
  digital_write_a: assert property ((i_reg_wr && i_reg_addr == CSTL_ADDR_DIGITAL)
    |=> dig_r == $past(i_reg_wdata))
    else $error("digital trim not stored");
  limit_write_a: assert property ((i_reg_wr && i_reg_addr == CSTL_ADDR_LIMIT)
    |=> lim_r == $past(i_reg_wdata))
    else $error("limit not stored");
  cfg_keep_a: assert property (!i_reg_wr |=> $stable(gain_r) && $stable(offs_r)
    && $stable(dig_r) && $stable(lim_r) && $stable(pri_setup_r))
    else $error("register changed without a write");
  pri_read_a: assert property ((i_reg_rd && i_reg_addr == CSTL_ADDR_PRI_READING)
    |=> o_reg_rdata == 8'($past(i_primary_reading)))
    else $error("primary reading read wrong");
  status_read_a: assert property ((i_reg_rd && i_reg_addr == CSTL_ADDR_STATUS)
    |=> o_reg_rdata[CSTL_STAT_SEC_BIT] == $past(o_secondary_over)
    && o_reg_rdata[CSTL_STAT_PRI_BIT] == $past(o_primary_over))
    else $error("status read wrong");
  limit_read_a: assert property ((i_reg_rd && i_reg_addr == CSTL_ADDR_LIMIT)
    |=> o_reg_rdata == $past(lim_r))
    else $error("limit read wrong");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  gain_read_a: assert property ((i_reg_rd && i_reg_addr == CSTL_ADDR_GAIN)
    |=> o_reg_rdata == $past(gain_r))
    else $error("gain register read wrong");
  offs_read_a: assert property ((i_reg_rd && i_reg_addr == CSTL_ADDR_OFFSET)
    |=> o_reg_rdata == $past(offs_r))
    else $error("offset register read wrong");
endmodule // cstl_top
`default_nettype wire

// ==== bench/current_sense_trim_and_limit_bench.sv ====
// Self-checking bench for the current sense trim and limit block
`timescale 1ns/100ps
`default_nettype none
module current_sense_trim_and_limit_bench
  import cstl_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_rd = 1'b0;
  logic i_cycle_start = 1'b0;
  logic [4:0] i_primary_reading = 5'h00;
  logic [7:0] i_secondary_raw = 8'h00;
  logic [7:0] o_reg_rdata;
  logic o_primary_over, o_secondary_over, o_quick_holdoff, o_gain_negative;
  logic o_highside, o_offset_negative;
  logic [1:0] o_secondary_range;
  logic [4:0] o_gain_magnitude;
  logic [5:0] o_offset_magnitude;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] rnd = 8'h11;
  int ns_tab [8] = '{0, 40, 80, 120, 200, 400, 600, 800};
  logic [7:0] trim_tab [5] = '{8'h00, 8'h00, 8'h05, 8'hFB, 8'h7F};
  logic [7:0] raw_tab [5] = '{8'hFE, 8'hFF, 8'h10, 8'h02, 8'hF0};
  logic [7:0] res_tab [5] = '{8'hFE, 8'hFF, 8'h15, 8'h00, 8'hFF};

  always #4 i_sys_clk = ~i_sys_clk;

  cstl_top dut_u (.i_sys_clk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
    .i_cycle_start, .i_primary_reading, .i_secondary_raw, .o_reg_rdata, .o_primary_over,
    .o_secondary_over, .o_quick_holdoff, .o_secondary_range, .o_gain_negative,
    .o_gain_magnitude, .o_highside, .o_offset_negative, .o_offset_magnitude);

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask

  // Expected value queued at request, compared when data shows
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    exp_q.push_back(want);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
  endtask

  always @(posedge i_sys_clk) rd_seen <= i_reg_rd;
  always @(negedge i_sys_clk) begin
    if (rd_seen && exp_q.size() == 0) check(o_reg_rdata, 8'hXX);
    else if (rd_seen) check(o_reg_rdata, exp_q.pop_front());
  end

  task automatic holdoff_run(input logic [2:0] code);
    int n;
    n = 0;
    reg_wr(CSTL_ADDR_PRI_SETUP, {code, 5'h1F});
    @(posedge i_sys_clk);
    i_cycle_start <= 1'b1;
    @(posedge i_sys_clk);
    i_cycle_start <= 1'b0;
    @(negedge i_sys_clk);
    while (o_quick_holdoff === 1'b1 && n < 120) begin
      n++;
      @(negedge i_sys_clk);
    end
    check(8'(n), 8'((ns_tab[code] + 7) / 8));
    if (n >= 120) final_report();
  endtask

  initial begin
    logic [7:0] v;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (int a = 8'h22; a <= 8'h28; a++) reg_rd(8'(a), 8'h00);
    // Trims first, so the threshold follows them; code 3 stays untested
    for (int r = 0; r < 3; r++) begin
      rnd = lfsr_next(rnd);
      v = {2'(r), rnd[5:0]};
      reg_wr(CSTL_ADDR_GAIN, v);
      reg_wr(CSTL_ADDR_OFFSET, rnd);
      @(negedge i_sys_clk);
      check({o_secondary_range, o_gain_negative, o_gain_magnitude}, v);
      check({o_highside, o_offset_negative, o_offset_magnitude}, rnd);
      reg_rd(CSTL_ADDR_OFFSET, rnd);
      reg_rd(CSTL_ADDR_GAIN, v);
    end
    for (int t = 0; t < 31; t += 15) begin
      reg_wr(CSTL_ADDR_PRI_SETUP, 8'(t));
      for (int d = 0; d < 2; d++) begin
        @(posedge i_sys_clk);
        i_primary_reading <= 5'(t + d);
        repeat (2) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check(8'(o_primary_over), 8'(d));
        reg_rd(CSTL_ADDR_PRI_READING, 8'(t + d));
        reg_rd(CSTL_ADDR_STATUS, 8'(d));
      end
    end
    reg_wr(CSTL_ADDR_LIMIT, 8'hFE);
    for (int k = 0; k < 5; k++) begin
      reg_wr(CSTL_ADDR_DIGITAL, trim_tab[k]);
      i_secondary_raw <= raw_tab[k];
      i_primary_reading <= 5'h00;
      repeat (3) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      check(8'(o_secondary_over), 8'(res_tab[k] > 8'hFE));
      reg_rd(CSTL_ADDR_SEC_RESULT, res_tab[k]);
      reg_rd(CSTL_ADDR_STATUS, {6'h00, res_tab[k] > 8'hFE, 1'b0});
    end
    for (int c = 0; c < 8; c++) holdoff_run(3'(c));
    // Read-only and unmapped places keep their contents
    reg_wr(8'h30, 8'hAA);
    reg_wr(CSTL_ADDR_SEC_RESULT, 8'h00);
    reg_wr(CSTL_ADDR_STATUS, 8'h00);
    reg_rd(8'h30, 8'h00);
    reg_rd(CSTL_ADDR_SEC_RESULT, 8'hFF);
    reg_rd(CSTL_ADDR_STATUS, 8'h02);
    reg_rd(CSTL_ADDR_LIMIT, 8'hFE);
    repeat (4) @(posedge i_sys_clk);
    if (exp_q.size() != 0) fails++;
    final_report();
  end

  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule // current_sense_trim_and_limit_bench
`default_nettype wire
